/* File: common/pcdc_regs.vh */
// constants of the clock generation and power-down control block
// assumes a 16-bit peripheral bus with word addresses and 8-bit registers
`ifndef PCDC_REGS_VH
`define PCDC_REGS_VH
// ***********************************************
// register addresses (word addresses) and reset values
// ***********************************************
`define PCDC_ADDR_PRIMARY   16'h702A
`define PCDC_ADDR_PRIMARY_M 16'h702B
`define PCDC_ADDR_RATIO     16'h702C
`define PCDC_ADDR_RATIO_M   16'h702D
`define PCDC_PRIMARY_RST    8'h00
`define PCDC_RATIO_RST      8'h00
// ***********************************************
// field positions and primary write mask
// ***********************************************
`define PCDC_SRC_HI         7
`define PCDC_SRC_LO         6
`define PCDC_LPM_HI         5
`define PCDC_LPM_LO         4
`define PCDC_LOCK_BIT       3
`define PCDC_PS_BIT         0
`define PCDC_CKINF_HI       7
`define PCDC_CKINF_LO       4
`define PCDC_DIV2_BIT       3
`define PCDC_MUL_HI         2
`define PCDC_MUL_LO         0
`define PCDC_PRIMARY_WMASK  8'hF1
// ***********************************************
// timing
// ***********************************************
`define PCDC_CLK_MHZ        250
`define PCDC_LOCK_US        100
`define PCDC_LOCK_CYC       (`PCDC_LOCK_US * `PCDC_CLK_MHZ)
`define PCDC_WD_PER_MHZ     61
`endif

/* File: verilog/pcdc_top.v */
// clock generation and power-down control, modelled on sys_clk
// assumes cpu strobes on sys_clk; pins and crystal input are asynchronous
`timescale 1ns/1ps
`include "pcdc_regs.vh"

module pcdc_top #(
  parameter LOCK_CYCLES = `PCDC_LOCK_CYC,
  parameter LOCK_W      = 16,
  parameter PW          = 16
) (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire [15:0] bus_addr,
  input  wire [15:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [15:0] bus_rdata,
  input  wire        osc_bypass_pin_n,
  input  wire        crystal_in_pin,
  output reg         crystal_out_pin,
  input  wire        nmi_pin,
  input  wire [2:0]  ext_int_pin,
  input  wire [2:0]  ext_int_enable,
  input  wire        periph_int_req,
  input  wire        idle_exec,
  input  wire        global_int_mask,
  output reg         pc_advance,
  output reg         wake_isr,
  output reg         wake_resume,
  output reg         core_clock,
  output reg         peripheral_clock,
  output reg         watchdog_tick_clock,
  output reg         pll_power,
  output reg         osc_enable,
  output reg         sleeping
);

  // ***********************************************
  // state codes and lock end point
  // ***********************************************
  localparam ST_RUN   = 1'b0;
  localparam ST_SLEEP = 1'b1;
  // last count before lock is set, cut to counter width
  localparam [31:0] LOCK_LAST = LOCK_CYCLES - 1;

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  reg [5:0] sync1_reg;
  reg [5:0] sync2_reg;
  reg       ref_prev_reg;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1_reg    <= 6'h00;
      sync2_reg    <= 6'h00;
      ref_prev_reg <= 1'b0;
    end else begin
      sync1_reg    <= {osc_bypass_pin_n, crystal_in_pin, nmi_pin,
                       ext_int_pin};
      sync2_reg    <= sync1_reg;
      ref_prev_reg <= sync2_reg[4];
    end
  end
  wire bypass_n = sync2_reg[5];
  wire ref_in   = sync2_reg[4];
  wire nmi_s    = sync2_reg[3];
  wire ref_rise = ref_in & ~ref_prev_reg;

  // ***********************************************
  // registers
  // ***********************************************
  reg  [7:0] primary_reg;
  reg  [7:0] ratio_reg;
  reg        lock_reg;
  reg        state_reg;
  reg  [1:0] mode_reg;
  wire hit_pri = (bus_addr == `PCDC_ADDR_PRIMARY) |
                 (bus_addr == `PCDC_ADDR_PRIMARY_M);
  wire hit_rat = (bus_addr == `PCDC_ADDR_RATIO) |
                 (bus_addr == `PCDC_ADDR_RATIO_M);
  wire [1:0] src_sel  = primary_reg[`PCDC_SRC_HI:`PCDC_SRC_LO];
  wire [1:0] lp_sel   = primary_reg[`PCDC_LPM_HI:`PCDC_LPM_LO];
  wire       ps_sel   = primary_reg[`PCDC_PS_BIT];
  wire [3:0] ckinf    = ratio_reg[`PCDC_CKINF_HI:`PCDC_CKINF_LO];
  wire       halve_in = ratio_reg[`PCDC_DIV2_BIT];
  wire [2:0] mul_sel  = ratio_reg[`PCDC_MUL_HI:`PCDC_MUL_LO];

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      primary_reg <= `PCDC_PRIMARY_RST;
      ratio_reg   <= `PCDC_RATIO_RST;
      bus_rdata   <= 16'h0000;
    end else begin
      if (bus_wr && hit_pri)
        primary_reg <= bus_wdata[7:0] & `PCDC_PRIMARY_WMASK;
      if (bus_wr && hit_rat)
        ratio_reg <= bus_wdata[7:0];
      if (bus_rd && hit_pri)
        bus_rdata <= {8'h00, primary_reg | {4'h0, lock_reg, 3'h0}};
      else if (bus_rd && hit_rat)
        bus_rdata <= {8'h00, ratio_reg};
      else
        bus_rdata <= 16'h0000;
    end
  end

  // ***********************************************
  // power-down sequencing
  // ***********************************************
  wire [2:0] ext_s  = sync2_reg[2:0] & ext_int_enable;
  wire       wake_hw = nmi_s | (|ext_s);
  wire       wake_any = wake_hw | ((mode_reg == 2'b00) & periph_int_req);
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_RUN;
      mode_reg    <= 2'b00;
      pc_advance  <= 1'b0;
      wake_isr    <= 1'b0;
      wake_resume <= 1'b0;
    end else begin
      pc_advance  <= 1'b0;
      wake_isr    <= 1'b0;
      wake_resume <= 1'b0;
      case (state_reg)
        ST_RUN: begin
          if (idle_exec) begin
            pc_advance <= 1'b1;
            mode_reg   <= lp_sel;
            state_reg  <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_reg <= ST_RUN;
            if (nmi_s)
              wake_isr <= 1'b1;
            else if (!global_int_mask)
              wake_isr <= 1'b1;
            else
              wake_resume <= 1'b1;
          end
        end
        default: state_reg <= ST_RUN;
      endcase
    end
  end

  // ***********************************************
  // clock stop decode per low-power mode
  // ***********************************************
  // clocks stopped by mode
  wire asleep   = (state_reg == ST_SLEEP);
  wire core_off = asleep;
  wire per_off  = asleep & (mode_reg != 2'b00);
  wire pll_off  = asleep & mode_reg[1];
  wire osc_off  = asleep & (mode_reg == 2'b11);

  // ***********************************************
  // pll enable, lock counter, factor latching
  // ***********************************************
  wire          pll_want = src_sel[1] & ~pll_off;
  reg  [LOCK_W-1:0] lock_cnt_reg;
  reg  [3:0]    pll_mul_reg;
  reg           pll_den_reg;
  reg           pll_on_reg;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_cnt_reg <= {LOCK_W{1'b0}};
      lock_reg     <= 1'b0;
      pll_mul_reg  <= 4'h1;
      pll_den_reg  <= 1'b0;
      pll_on_reg   <= 1'b0;
    end else begin
      pll_on_reg <= pll_want;
      if (!pll_want) begin
        lock_cnt_reg <= {LOCK_W{1'b0}};
        lock_reg     <= 1'b0;
      end else if (!pll_on_reg) begin
        case (mul_sel)
          3'h0: pll_mul_reg <= 4'h1;
          3'h1: pll_mul_reg <= 4'h2;
          3'h2: pll_mul_reg <= 4'h3;
          3'h3: pll_mul_reg <= 4'h4;
          3'h4: pll_mul_reg <= 4'h5;
          default: pll_mul_reg <= 4'h9;
        endcase
        pll_den_reg <= halve_in;
      end else if (!lock_reg) begin
        if (lock_cnt_reg == LOCK_LAST[LOCK_W-1:0])
          lock_reg <= 1'b1;
        else
          lock_cnt_reg <= lock_cnt_reg + 1'b1;
      end
    end
  end

  // ***********************************************
  // reference period measure and core synthesis
  // ***********************************************
  reg  [PW-1:0] per_cnt_reg;
  reg  [PW-1:0] per_reg;
  reg  [PW+3:0] acc_reg;
  reg  [3:0]    eff_mul_reg;
  reg           eff_den_reg;
  reg           core_ph_reg;
  wire [3:0] want_mul = (src_sel[1] & lock_reg) ? pll_mul_reg : 4'h1;
  wire       want_den = (src_sel[1] & lock_reg) ? pll_den_reg :
                        ~src_sel[0];
  wire [PW+3:0] thresh = eff_den_reg ? {3'h0, per_reg, 1'b0} :
                                       {4'h0, per_reg};
  wire [PW+3:0] acc_add = acc_reg + {{(PW-1){1'b0}}, eff_mul_reg, 1'b0};
  wire core_edge = (per_reg != {PW{1'b0}}) & (acc_add >= thresh);
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_cnt_reg <= {PW{1'b0}};
      per_reg     <= {PW{1'b0}};
      acc_reg     <= {(PW+4){1'b0}};
      eff_mul_reg <= 4'h1;
      eff_den_reg <= 1'b1;
      core_ph_reg <= 1'b0;
    end else begin
      if (ref_rise) begin
        per_reg     <= per_cnt_reg + 1'b1;
        per_cnt_reg <= {PW{1'b0}};
      end else if (per_cnt_reg != {PW{1'b1}}) begin
        per_cnt_reg <= per_cnt_reg + 1'b1;
      end
      if (core_edge) begin
        acc_reg     <= acc_add - thresh;
        core_ph_reg <= ~core_ph_reg;
        if (core_ph_reg) begin
          eff_mul_reg <= want_mul;
          eff_den_reg <= want_den;
        end
      end else begin
        acc_reg <= acc_add;
      end
    end
  end
  wire core_rise = core_edge & ~core_ph_reg;

  // ***********************************************
  // derived clocks
  // ***********************************************
  reg  [1:0]  per_div_reg;
  reg  [15:0] wd_cnt_reg;
  // watchdog period in core cycles from declared input frequency
  // declared input rate reaches 32 MHz, so six bits
  wire [5:0]  in_mhz   = {(5'h10 - {1'b0, ckinf}), 1'b0};
  wire [15:0] wd_full  = in_mhz * eff_mul_reg * `PCDC_WD_PER_MHZ;
  wire [15:0] wd_per   = eff_den_reg ? {1'b0, wd_full[15:1]} : wd_full;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      per_div_reg         <= 2'h0;
      wd_cnt_reg          <= 16'h0000;
      core_clock          <= 1'b0;
      peripheral_clock    <= 1'b0;
      watchdog_tick_clock <= 1'b0;
      pll_power           <= 1'b0;
      osc_enable          <= 1'b0;
      crystal_out_pin     <= 1'b0;
      sleeping            <= 1'b0;
    end else begin
      core_clock <= core_ph_reg & ~core_off;
      if (core_rise)
        per_div_reg <= per_div_reg + 1'b1;
      peripheral_clock <= ~per_off &
                          (ps_sel ? per_div_reg[0] : per_div_reg[1]);

      // ***********************************************
      // watchdog tick divider, then power, oscillator and sleep outputs
      // ***********************************************
      if (core_rise)
        wd_cnt_reg <= (wd_cnt_reg >= wd_per - 1'b1) ? 16'h0000 :
                      wd_cnt_reg + 1'b1;
      watchdog_tick_clock <= ~pll_off & (wd_cnt_reg < {2'b00, wd_per[15:2]});
      pll_power  <= pll_want;
      osc_enable <= bypass_n & ~osc_off;
      crystal_out_pin <= bypass_n & ~osc_off & ~ref_in;
      sleeping   <= asleep;
    end
  end
endmodule

/* File: bench/pcdc_top_sva.sv */
// checker of the clock and power-down block
// bound to pcdc_top, sees its ports only
`timescale 1ns/1ps
module pcdc_top_sva (
  input wire        sys_clk,
  input wire        rst,
  input wire [15:0] bus_addr,
  input wire        bus_rd,
  input wire [15:0] bus_rdata,
  input wire        nmi_pin,
  input wire [2:0]  ext_int_pin,
  input wire [2:0]  ext_int_enable,
  input wire        periph_int_req,
  input wire        idle_exec,
  input wire        global_int_mask,
  input wire        pc_advance,
  input wire        wake_isr,
  input wire        wake_resume,
  input wire        core_clock,
  input wire        sleeping
);
  reg [3:0] quiet_reg;
  // cycles since any wake source was high
  always @(posedge sys_clk or posedge rst)
    if (rst)
      quiet_reg <= 4'h0;
    else if (nmi_pin || (|ext_int_pin) || periph_int_req)
      quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF)
      quiet_reg <= quiet_reg + 4'h1;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  a_pc_after_idle:
    assert property (idle_exec && !sleeping |=> pc_advance)
    else $error("no pc advance after idle");
  a_pc_single_pulse:
    assert property (pc_advance |=> !pc_advance)
    else $error("pc advance longer than one cycle");
  a_idle_sleeps:
    assert property (idle_exec && !sleeping |-> ##2 sleeping)
    else $error("idle did not enter power-down");
  a_sleep_holds:
    assert property (sleeping && quiet_reg > 4'h4 |=> sleeping)
    else $error("left power-down without wake");
  a_core_stopped:
    assert property (sleeping && $past(sleeping, 2) |-> !core_clock)
    else $error("core clock runs while asleep");
  a_nmi_isr:
    assert property (sleeping && nmi_pin |-> ##[0:5] wake_isr)
    else $error("nmi wake without service");
  a_unmasked_isr:
    assert property (sleeping && !global_int_mask
      && |(ext_int_pin & ext_int_enable) |-> ##[0:5] wake_isr)
    else $error("unmasked wake without service");
  a_masked_resume:
    assert property (sleeping && global_int_mask && !nmi_pin
      && |(ext_int_pin & ext_int_enable) |-> ##[0:5] wake_resume)
    else $error("masked wake did not resume");
  a_unmapped_zero:
    assert property (bus_rd && bus_addr == 16'h702E |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_rdata_one_cycle:
    assert property (!$past(bus_rd) |-> bus_rdata == 16'h0000)
    else $error("read data held too long");
  cover property (wake_resume);
  cover property (wake_isr && global_int_mask);
  cover property (sleeping && periph_int_req);
endmodule
bind pcdc_top pcdc_top_sva i_pcdc_top_sva (
  .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_rd(bus_rd),
  .bus_rdata(bus_rdata), .nmi_pin(nmi_pin), .ext_int_pin(ext_int_pin),
  .ext_int_enable(ext_int_enable), .periph_int_req(periph_int_req),
  .idle_exec(idle_exec), .global_int_mask(global_int_mask),
  .pc_advance(pc_advance), .wake_isr(wake_isr), .wake_resume(wake_resume),
  .core_clock(core_clock), .sleeping(sleeping));

/* File: bench/pcdc_cpu_model.sv */
// cpu side model: peripheral bus cycles and reference clock
// strobes change just after sys_clk rising edges
`timescale 1ns/1ps
module pcdc_cpu_model (
  input  wire        sys_clk,
  output reg  [15:0] bus_addr,
  output reg  [15:0] bus_wdata,
  output reg         bus_wr,
  output reg         bus_rd,
  input  wire [15:0] bus_rdata,
  output reg         crystal_in_pin
);
  initial begin
    bus_addr = 16'h0000;
    bus_wdata = 16'h0000;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    crystal_in_pin = 1'b0;
  end
  // free running reference, 40 sys_clk period
  initial
    forever #80 crystal_in_pin = ~crystal_in_pin;
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
    end
  endtask
  task rd(input [15:0] a, output [15:0] d);
    begin
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      bus_addr <= ~a;
      #1 d = bus_rdata;
    end
  endtask
endmodule

/* File: bench/pcdc_top_tb.sv */
// self-checking bench of the clock and power-down block
// cpu model drives the bus and crystal input; other pins and idle driven here
`timescale 1ns/1ps
module pcdc_top_tb;
  reg         sys_clk;
  reg         rst;
  reg         nmi_pin;
  reg  [2:0]  ext_int_pin;
  reg         periph_int_req;
  reg         idle_exec;
  reg         global_int_mask;
  wire [15:0] bus_addr;
  wire [15:0] bus_wdata;
  wire        bus_wr;
  wire        bus_rd;
  wire [15:0] bus_rdata;
  wire        crystal_in_pin;
  wire        pc_advance;
  wire        wake_isr;
  wire        wake_resume;
  wire        core_clock;
  wire        peripheral_clock;
  wire        sleeping;
  wire        pll_power;
  wire        osc_enable;
  integer     errors;
  integer     checks_done;
  integer     cyc;
  integer     nc;
  integer     np;
  integer     i;
  reg  [15:0] rv;
  pcdc_cpu_model i_cpu (
    .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .crystal_in_pin(crystal_in_pin));
  pcdc_top #(.LOCK_CYCLES(16)) i_pcdc_top (
    .sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .osc_bypass_pin_n(1'b1),
    .crystal_in_pin(crystal_in_pin), .crystal_out_pin(),
    .nmi_pin(nmi_pin), .ext_int_pin(ext_int_pin),
    .ext_int_enable(3'h1), .periph_int_req(periph_int_req),
    .idle_exec(idle_exec), .global_int_mask(global_int_mask),
    .pc_advance(pc_advance), .wake_isr(wake_isr), .wake_resume(wake_resume),
    .core_clock(core_clock), .peripheral_clock(peripheral_clock),
    .watchdog_tick_clock(), .pll_power(pll_power), .osc_enable(osc_enable),
    .sleeping(sleeping));
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge core_clock) nc = nc + 1;
  always @(posedge peripheral_clock) np = np + 1;
  task check(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rd_chk(input [15:0] a, input [15:0] exp);
    begin
      i_cpu.rd(a, rv);
      check(rv, exp);
    end
  endtask
  task report_and_stop;
    begin
      $display("errors=%0d checks_done=%0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // src: 0 peripheral, 1 external pin, 2 nmi
  task sleep_wake(input [1:0] m, input [1:0] src, input msk);
    reg [1:0] got;
    integer   k;
    begin
      i_cpu.wr(16'h702A, {10'h000, m, 4'h1});
      @(posedge sys_clk);
      global_int_mask <= msk;
      idle_exec <= 1'b1;
      @(posedge sys_clk);
      idle_exec <= 1'b0;
      #1 check({15'h0000, pc_advance}, 16'h0001);
      repeat (8) @(posedge sys_clk);
      periph_int_req <= (m == 2'b01);
      @(posedge sys_clk);
      periph_int_req <= 1'b0;
      repeat (6) @(posedge sys_clk);
      #1 check({14'h0000, sleeping, core_clock}, 16'h0002);
      @(posedge sys_clk);
      nmi_pin <= (src == 2'd2);
      ext_int_pin <= {2'b00, src == 2'd1};
      periph_int_req <= (src == 2'd0);
      got = 2'b00;
      for (k = 0; k < 10; k = k + 1) begin
        @(posedge sys_clk);
        #1 got = got | {wake_isr, wake_resume};
      end
      @(posedge sys_clk);
      nmi_pin <= 1'b0;
      ext_int_pin <= 3'h0;
      periph_int_req <= 1'b0;
      check({14'h0000, got}, (src == 2'd2 || !msk) ? 16'h2 : 16'h1);
      #1 check({15'h0000, sleeping}, 16'h0000);
    end
  endtask
  task ratio_chk(input integer dv);
    begin
      repeat (20) @(posedge sys_clk);
      nc = 0;
      np = 0;
      repeat (3000) @(posedge sys_clk);
      check((nc - np * dv <= dv && np * dv - nc <= dv) ? 16'h1 : 16'h0, 16'h1);
    end
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      errors = errors + 1;
      report_and_stop;
    end
  end
  initial begin
    errors = 0;
    checks_done = 0;
    cyc = 0;
    nc = 0;
    np = 0;
    rst = 1'b1;
    nmi_pin = 1'b0;
    ext_int_pin = 3'h0;
    periph_int_req = 1'b0;
    idle_exec = 1'b0;
    global_int_mask = 1'b0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd_chk(16'h702A, 16'h0000);
    rd_chk(16'h702C, 16'h0000);
    i_cpu.wr(16'h702A, 16'hAB3F);
    rd_chk(16'h702B, 16'h0031);
    i_cpu.wr(16'h702D, 16'h12FD);
    rd_chk(16'h702C, 16'h00FD);
    rd_chk(16'h702E, 16'h0000);
    sleep_wake(2'd0, 2'd0, 1'b0);
    sleep_wake(2'd1, 2'd1, 1'b1);
    sleep_wake(2'd2, 2'd2, 1'b1);
    sleep_wake(2'd3, 2'd1, 1'b0);
    i_cpu.wr(16'h702C, 16'h0002);
    i_cpu.wr(16'h702A, 16'h0081);
    rv = 16'h0000;
    for (i = 0; i < 300 && rv[3] !== 1'b1; i = i + 1)
      i_cpu.rd(16'h702A, rv);
    check(rv, 16'h0089);
    check({14'h0000, pll_power, osc_enable}, 16'h0003);
    ratio_chk(2);
    i_cpu.wr(16'h702A, 16'h0080);
    ratio_chk(4);
    report_and_stop;
  end
endmodule
